// ---- bench/modbus_param_config_slave_tb_top.sv ----
// Self-checking bench for the configuration handler
`timescale 1ns/1ps
module modbus_param_config_slave_tb_top
	import mpc_pkg::*;
;
	localparam logic [16:0] BPS [8] = '{17'h00000, 17'h00960, 17'h012C0, 17'h02580,
		17'h04B00, 17'h09600, 17'h1C200, 17'h00000};
	logic [15:0] cv [7] = '{16'h03E8, 16'h03E9, 16'hFC16, 16'hFC17, 16'hFFFF, 16'h0000,
		16'hFC18};
	logic [15:0] rg [4] = '{16'h0066, 16'h0067, 16'h006B, 16'h0068};
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        stall = 1'b0;
	logic        slow = 1'b0;
	logic        ce = 1'b1;
	logic        miv = 1'b0;
	logic [15:0] mi = 16'h0000;
	logic [7:0]  sa = 8'h01;
	logic [2:0]  bc = 3'h3;
	logic [15:0] co = 16'h0000;
	logic [31:0] seed = 32'h3A30BD8A;
	logic [31:0] x;
	mpc_byte_t   rx_byte;
	mpc_byte_t   tx_q;
	logic        rx_frame_end;
	logic        tx_ready;
	logic        mov;
	logic [7:0]  addr;
	logic [2:0]  code;
	logic [16:0] bps;
	logic [15:0] corr;
	logic [15:0] mo;
	int          err_count = 0;
	int          compares = 0;

	always #4 clk = ~clk;

	mpc_config_slave dut (.clk, .rst, .ce, .rx_byte, .rx_frame_end, .tx_ready, .tx_q,
		.slave_address_q(addr), .baud_rate_code_q(code), .baud_rate_bps_q(bps),
		.measurement_correction_q(corr), .meas_in(mi), .meas_in_valid(miv),
		.meas_out_q(mo), .meas_out_valid_q(mov));
	mpc_master_model m (.clk, .stall, .tx_q, .rx_byte, .rx_frame_end, .tx_ready);

	function automatic logic [31:0] lfsr();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction : lfsr

	function automatic logic [15:0] sat(input logic [15:0] v, c);
		int s;
		s = int'(v) + int'($signed(c));
		return s < 0 ? 16'h0000 : s > 32'h0000FFFF ? 16'hFFFF : 16'(s);
	endfunction : sat

	always @(posedge clk) stall <= slow && lfsr() > 32'h60000000;

	task automatic close_out();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out

	task automatic check(input logic [16:0] s, e);
		compares++;
		if (s !== e) begin
			err_count++;
			$display("BAD at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : check

	// Mirrors the register file to predict each reply, or its absence
	task automatic op(input logic [7:0] a, f, input logic [15:0] r, v, input logic bad);
		logic [7:0]  e [$];
		logic [15:0] rv;
		logic [15:0] c;
		logic        ok;
		int          n;
		rv = r == 16'h0066 ? {8'h00, sa} : r == 16'h0067 ? {13'h0000, bc} : co;
		ok = (a == sa || a == 8'hFA) && !bad && r inside {16'h0066, 16'h0067, 16'h006B};
		if (f == 8'h03)
			ok &= v == 16'h0001;
		else if (r == 16'h0066)
			ok &= f == 8'h06 && v inside {[16'h0001:16'h00F9]};
		else if (r == 16'h0067)
			ok &= f == 8'h06 && v inside {[16'h0001:16'h0006]};
		else
			ok &= f == 8'h06 && (v <= 16'h03E8 || v >= 16'hFC17);
		m.send({a, f, r[15:8], r[7:0], v[15:8], v[7:0]}, bad);
		if (ok && f == 8'h06) begin
			sa = r == 16'h0066 ? v[7:0] : sa;
			bc = r == 16'h0067 ? v[2:0] : bc;
			co = r == 16'h006B ? v : co;
			e = {sa, f, r[15:8], r[7:0], v[15:8], v[7:0]};
		end else if (ok)
			e = {sa, f, 8'h02, rv[15:8], rv[7:0]};
		c = m.crc(e);
		if (ok)
			e = {e, c[7:0], c[15:8]};
		n = 0;
		while (m.rsp.size() < e.size() && n < 400) begin
			@(posedge clk);
			n++;
		end
		repeat (ok ? 3 : 40) @(posedge clk);
		check(17'(m.rsp.size()), 17'(e.size()));
		foreach (e[i]) check(17'(m.rsp[i]), 17'(e[i]));
		void'(lfsr());
		mi <= seed[0] ? seed[31:16] : {11'h000, seed[20:16]};
		miv <= 1'b1;
		@(posedge clk);
		miv <= 1'b0;
		#1;
		check(17'(mov), 17'h00001);
		check(17'(mo), 17'(sat(mi, co)));
		check(17'(addr), 17'(sa));
		check(17'(corr), 17'(co));
		check(17'(code), 17'(bc));
		check(bps, BPS[bc]);
	endtask : op

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		// Only one slave sits on this bus, so the universal address is safe
		op(8'hFA, 8'h03, 16'h0066, 16'h0001, 1'b0);
		op(8'h01, 8'h03, 16'h0067, 16'h0001, 1'b0);
		op(8'hFA, 8'h03, 16'h006B, 16'h0001, 1'b0);
		$display("test 1 done");
		op(8'h01, 8'h06, 16'h0066, 16'h0002, 1'b0);
		op(8'h01, 8'h03, 16'h0066, 16'h0001, 1'b0);
		op(8'h02, 8'h03, 16'h0066, 16'h0002, 1'b0);
		op(8'h02, 8'h03, 16'h0066, 16'h0001, 1'b0);
		op(8'h02, 8'h03, 16'h0066, 16'h0001, 1'b1);
		op(8'h02, 8'h06, 16'h0066, 16'h00FA, 1'b0);
		op(8'h02, 8'h06, 16'h0066, 16'h0000, 1'b0);
		$display("test 2 done");
		slow <= 1'b1;
		for (int i = 0; i < 8; i++)
			op(8'hFA, 8'h06, 16'h0067, 16'(i), 1'b0);
		foreach (cv[i])
			op(sa, 8'h06, 16'h006B, cv[i], 1'b0);
		op(sa, 8'h03, 16'h006B, 16'h0001, 1'b0);
		$display("test 3 done");
		for (int i = 0; i < 60; i++) begin
			x = lfsr();
			op(x[0] ? sa : x[1] ? 8'hFA : x[15:8], x[2] ? 8'h06 : x[3] ? 8'h03 : x[23:16],
				rg[x[5:4]], x[6] ? {13'h0000, x[9:7]} : x[31:16], x[10] & x[11]);
		end
		$display("test 4 done");
		// Reset is raised on a clock edge so the bench never drives between edges
		@(posedge clk);
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		sa = 8'h01;
		bc = 3'h3;
		co = 16'h0000;
		op(8'hFA, 8'h03, 16'h0066, 16'h0001, 1'b0);
		// With the enable low a measurement strobe must leave no trace
		@(posedge clk);
		ce <= 1'b0;
		miv <= 1'b1;
		@(posedge clk);
		#1;
		check(17'(mov), 17'h00000);
		check(17'(addr), 17'(sa));
		@(posedge clk);
		ce <= 1'b1;
		miv <= 1'b0;
		$display("test 5 done");
		close_out();
	end

	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		close_out();
	end
endmodule : modbus_param_config_slave_tb_top

// ---- bench/mpc_config_slave_properties.sv ----
// Port-level checks on the configuration handler
`timescale 1ns/1ps
module mpc_config_slave_properties
	import mpc_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        ce,
	input wire mpc_byte_t   rx_byte,
	input wire logic        rx_frame_end,
	input wire logic        tx_ready,
	input wire mpc_byte_t   tx_q,
	input wire logic [7:0]  slave_address_q,
	input wire logic [2:0]  baud_rate_code_q,
	input wire logic [16:0] baud_rate_bps_q,
	input wire logic [15:0] measurement_correction_q,
	input wire logic [15:0] meas_in,
	input wire logic        meas_in_valid,
	input wire logic [15:0] meas_out_q,
	input wire logic        meas_out_valid_q
);
	localparam logic [16:0] BPS [8] = '{17'h00000, 17'h00960, 17'h012C0, 17'h02580,
		17'h04B00, 17'h09600, 17'h1C200, 17'h00000};

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	function automatic logic [15:0] sat(input logic [15:0] m, c);
		int s;
		s = int'(m) + int'($signed(c));
		return s < 0 ? 16'h0000 : s > 32'h0000FFFF ? 16'hFFFF : 16'(s);
	endfunction : sat

	property p_rst_addr;
		$fell(rst) |-> slave_address_q == 8'h01;
	endproperty
	a_rst_addr: assert property (p_rst_addr) else $error("address wrong after reset");
	property p_rst_baud;
		$fell(rst) |-> baud_rate_code_q == 3'h3 && baud_rate_bps_q == 17'h02580;
	endproperty
	a_rst_baud: assert property (p_rst_baud) else $error("baud wrong after reset");
	property p_bps;
		1'b1 |-> baud_rate_bps_q == BPS[$past(baud_rate_code_q)];
	endproperty
	a_bps: assert property (p_bps) else $error("baud rate not decoded");
	property p_range;
		slave_address_q inside {[8'h01:8'hF9]} && baud_rate_code_q inside {[3'h1:3'h6]};
	endproperty
	a_range: assert property (p_range) else $error("stored value out of range");
	property p_corr;
		measurement_correction_q <= 16'h03E8 || measurement_correction_q >= 16'hFC17;
	endproperty
	a_corr: assert property (p_corr) else $error("correction out of range");
	property p_meas;
		ce && meas_in_valid |=> meas_out_valid_q
			&& meas_out_q == sat($past(meas_in), $past(measurement_correction_q));
	endproperty
	a_meas: assert property (p_meas) else $error("corrected value wrong");
	property p_hold;
		ce && tx_q.valid && !tx_ready |=> $stable(tx_q);
	endproperty
	a_hold: assert property (p_hold) else $error("reply byte not held");
	property p_gap;
		ce && tx_q.valid && tx_ready |=> !tx_q.valid;
	endproperty
	a_gap: assert property (p_gap) else $error("no gap after accepted byte");
	// A register may only move right after a frame is judged
	property p_upd;
		$changed({slave_address_q, baud_rate_code_q, measurement_correction_q})
			|-> $past(rx_frame_end) || $past(rx_frame_end, 2) || $past(rx_frame_end, 3);
	endproperty
	a_upd: assert property (p_upd) else $error("register moved without a frame");
endmodule : mpc_config_slave_properties

bind mpc_config_slave mpc_config_slave_properties u_props (.clk, .rst, .ce, .rx_byte,
	.rx_frame_end, .tx_ready, .tx_q, .slave_address_q, .baud_rate_code_q,
	.baud_rate_bps_q, .measurement_correction_q, .meas_in, .meas_in_valid, .meas_out_q,
	.meas_out_valid_q);

// ---- bench/mpc_master_model.sv ----
// Host model: sends request frames and gathers reply bytes
`timescale 1ns/1ps
module mpc_master_model
	import mpc_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      stall,
	input  wire mpc_byte_t tx_q,
	output mpc_byte_t      rx_byte,
	output logic           rx_frame_end,
	output logic           tx_ready
);
	logic [7:0] rsp [$];

	initial begin
		rx_byte = '0;
		rx_frame_end = 1'b0;
		tx_ready = 1'b1;
	end

	// A slow host stalls at random; no reply byte may be lost meanwhile
	always @(posedge clk) begin
		if (tx_q.valid && tx_ready)
			rsp.push_back(tx_q.data);
		tx_ready <= !stall;
	end

	function automatic logic [15:0] crc(input logic [7:0] f [$]);
		logic [15:0] c;
		c = MPC_CRC_INIT;
		foreach (f[i]) begin
			c ^= {8'h00, f[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ MPC_CRC_POLY : c >> 1;
		end
		return c;
	endfunction : crc

	task automatic send(input logic [7:0] f [$], input logic bad);
		logic [15:0] c;
		c = crc(f) ^ {15'h0000, bad};
		f = {f, c[7:0], c[15:8]};
		rsp.delete();
		foreach (f[i]) begin
			@(posedge clk);
			rx_byte <= '{1'b1, f[i]};
			@(posedge clk);
			rx_byte <= '{1'b0, ~f[i]};
		end
		@(posedge clk);
		rx_frame_end <= 1'b1;
		@(posedge clk);
		rx_frame_end <= 1'b0;
	endtask : send
endmodule : mpc_master_model

// ---- verilog/mpc_config_slave.sv ----
// Modbus RTU parameter-configuration command handler
`timescale 1ns/1ps
module mpc_config_slave
	import mpc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire mpc_byte_t   rx_byte,
	input  wire logic        rx_frame_end,
	input  wire logic        tx_ready,
	output mpc_byte_t        tx_q,
	output logic      [7:0]  slave_address_q,
	output logic      [2:0]  baud_rate_code_q,
	output logic      [16:0] baud_rate_bps_q,
	output logic      [15:0] measurement_correction_q,
	input  wire logic [15:0] meas_in,
	input  wire logic        meas_in_valid,
	output logic      [15:0] meas_out_q,
	output logic             meas_out_valid_q
);

	typedef enum logic [2:0] {
		MPC_ST_RX,
		MPC_ST_EXEC,
		MPC_ST_TX,
		MPC_ST_CRC_LO,
		MPC_ST_CRC_HI
	} mpc_state_t;

	mpc_state_t  state_q;
	logic [7:0]  rx_buf_q [0:7];
	logic [3:0]  rx_cnt_q;
	logic        rx_over_q;
	logic [7:0]  tx_buf_q [0:5];
	logic [2:0]  tx_len_q;
	logic [2:0]  tx_idx_q;
	logic [15:0] rx_crc;
	logic [15:0] tx_crc;
	logic        rx_take;
	logic        frame_ok;
	logic        tx_load;
	logic        tx_accept;
	logic [7:0]  tx_next;
	logic [7:0]  req_addr;
	logic [7:0]  req_fn;
	logic [15:0] req_reg;
	logic [15:0] req_val;
	logic        addr_hit;
	logic        is_read;
	logic        is_write;
	logic        wr_addr_ok;
	logic        wr_baud_ok;
	logic        wr_corr_ok;
	logic        rd_known;
	logic        do_write;
	logic        do_reply;
	logic [15:0] rd_value;

	// Incoming bytes are only collected while idle; a frame that overlaps a reply is lost
	assign rx_take  = (state_q == MPC_ST_RX) && rx_byte.valid;

	assign req_addr = rx_buf_q[0];
	assign req_fn   = rx_buf_q[1];
	assign req_reg  = {rx_buf_q[2], rx_buf_q[3]};
	assign req_val  = {rx_buf_q[4], rx_buf_q[5]};

	// Matching uses the live address register, so a change holds from the next frame
	assign addr_hit = (req_addr == slave_address_q) || (req_addr == MPC_UNIVERSAL_ADDR);

	// CRC over all eight bytes, trailer included, leaves zero when intact
	assign frame_ok = (rx_cnt_q == MPC_REQ_LEN) && !rx_over_q && (rx_crc == 16'h0000) && addr_hit;

	assign is_read  = (req_fn == MPC_FN_READ) && (req_val == MPC_READ_QTY);
	assign is_write = (req_fn == MPC_FN_WRITE);

	assign wr_addr_ok = (req_val >= MPC_ADDR_MIN) && (req_val <= MPC_ADDR_MAX);
	assign wr_baud_ok = (req_val >= MPC_BAUD_MIN) && (req_val <= MPC_BAUD_MAX);
	assign wr_corr_ok = (req_val <= MPC_CORR_POS_MAX) || (req_val >= MPC_CORR_NEG_MIN);

	assign rd_known = (req_reg == MPC_REG_SLAVE_ADDRESS) || (req_reg == MPC_REG_BAUD_CODE)
		|| (req_reg == MPC_REG_CORRECTION);

	always_comb begin
		do_write = 1'b0;
		if (is_write) begin
			unique case (req_reg)
				MPC_REG_SLAVE_ADDRESS: do_write = wr_addr_ok;
				MPC_REG_BAUD_CODE:     do_write = wr_baud_ok;
				MPC_REG_CORRECTION:    do_write = wr_corr_ok;
				default:               do_write = 1'b0;
			endcase
		end
	end

	// Unknown registers and malformed requests get no reply at all
	assign do_reply = (is_read && rd_known) || do_write;

	always_comb begin
		rd_value = 16'h0000;
		unique case (req_reg)
			MPC_REG_SLAVE_ADDRESS: rd_value = {8'h00, slave_address_q};
			MPC_REG_BAUD_CODE:     rd_value = {13'h0000, baud_rate_code_q};
			MPC_REG_CORRECTION:    rd_value = measurement_correction_q;
			default:               rd_value = 16'h0000;
		endcase
	end

	mpc_crc16 u_rx_crc (
		.clk   (clk),
		.rst   (rst),
		.ce    (ce),
		.clear (state_q == MPC_ST_EXEC || (state_q == MPC_ST_RX && rx_frame_end)),
		.en    (rx_take),
		.data  (rx_byte.data),
		.crc_q (rx_crc)
	);

	// Receive buffer: the first eight bytes are kept, longer frames are marked bad
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_cnt_q  <= 4'h0;
			rx_over_q <= 1'b0;
		end else if (ce) begin
			if (state_q != MPC_ST_RX || rx_frame_end) begin
				rx_cnt_q  <= 4'h0;
				rx_over_q <= 1'b0;
			end else if (rx_byte.valid) begin
				if (rx_cnt_q == MPC_REQ_LEN) begin
					rx_over_q <= 1'b1;
				end else begin
					rx_buf_q[rx_cnt_q[2:0]] <= rx_byte.data;
					rx_cnt_q                <= rx_cnt_q + 4'h1;
				end
			end
		end
	end

	// Frame sequencing
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q  <= MPC_ST_RX;
			tx_idx_q <= 3'h0;
		end else if (ce) begin
			unique case (state_q)
				MPC_ST_RX: begin
					if (rx_frame_end && frame_ok) begin
						state_q <= MPC_ST_EXEC;
					end
				end
				MPC_ST_EXEC: begin
					tx_idx_q <= 3'h0;
					state_q  <= do_reply ? MPC_ST_TX : MPC_ST_RX;
				end
				MPC_ST_TX: begin
					if (tx_accept) begin
						if (tx_idx_q == tx_len_q - 3'h1) begin
							state_q <= MPC_ST_CRC_LO;
						end else begin
							tx_idx_q <= tx_idx_q + 3'h1;
						end
					end
				end
				MPC_ST_CRC_LO: begin
					if (tx_accept) begin
						state_q <= MPC_ST_CRC_HI;
					end
				end
				MPC_ST_CRC_HI: begin
					if (tx_accept) begin
						state_q <= MPC_ST_RX;
					end
				end
			endcase
		end
	end

	// Configuration registers, updated in the execute cycle so the reply reflects them
	always_ff @(posedge clk) begin
		if (rst) begin
			slave_address_q          <= MPC_RST_SLAVE_ADDRESS;
			baud_rate_code_q         <= MPC_RST_BAUD_CODE;
			measurement_correction_q <= MPC_RST_CORRECTION;
		end else if (ce && state_q == MPC_ST_EXEC && do_write) begin
			unique case (req_reg)
				MPC_REG_SLAVE_ADDRESS: slave_address_q <= req_val[7:0];
				MPC_REG_BAUD_CODE:     baud_rate_code_q <= req_val[2:0];
				MPC_REG_CORRECTION:    measurement_correction_q <= req_val;
				default:               slave_address_q <= slave_address_q;
			endcase
		end
	end

	// Rate handed to the serial port; the reply already goes out at the new rate
	always_ff @(posedge clk) begin
		if (rst) begin
			baud_rate_bps_q <= MPC_BAUD_3;
		end else if (ce) begin
			unique case (baud_rate_code_q)
				3'h1:    baud_rate_bps_q <= MPC_BAUD_1;
				3'h2:    baud_rate_bps_q <= MPC_BAUD_2;
				3'h3:    baud_rate_bps_q <= MPC_BAUD_3;
				3'h4:    baud_rate_bps_q <= MPC_BAUD_4;
				3'h5:    baud_rate_bps_q <= MPC_BAUD_5;
				3'h6:    baud_rate_bps_q <= MPC_BAUD_6;
				default: baud_rate_bps_q <= MPC_BAUD_3;
			endcase
		end
	end

	// Reply assembly
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_len_q <= MPC_RSP_READ_LEN;
		end else if (ce && state_q == MPC_ST_EXEC) begin
			if (is_write) begin
				// Echo of the request, with the address the slave now answers to
				tx_buf_q[0] <= (req_reg == MPC_REG_SLAVE_ADDRESS) ? req_val[7:0] : slave_address_q;
				tx_buf_q[1] <= req_fn;
				tx_buf_q[2] <= rx_buf_q[2];
				tx_buf_q[3] <= rx_buf_q[3];
				tx_buf_q[4] <= rx_buf_q[4];
				tx_buf_q[5] <= rx_buf_q[5];
				tx_len_q    <= MPC_RSP_WRITE_LEN;
			end else begin
				tx_buf_q[0] <= slave_address_q;
				tx_buf_q[1] <= MPC_FN_READ;
				tx_buf_q[2] <= MPC_READ_BYTES;
				tx_buf_q[3] <= rd_value[15:8];
				tx_buf_q[4] <= rd_value[7:0];
				tx_buf_q[5] <= 8'h00;
				tx_len_q    <= MPC_RSP_READ_LEN;
			end
		end
	end

	assign tx_load   = (state_q == MPC_ST_TX || state_q == MPC_ST_CRC_LO
		|| state_q == MPC_ST_CRC_HI) && !tx_q.valid;
	assign tx_accept = tx_q.valid && tx_ready;

	always_comb begin
		tx_next = tx_buf_q[tx_idx_q];
		if (state_q == MPC_ST_CRC_LO) begin
			tx_next = tx_crc[7:0];
		end else if (state_q == MPC_ST_CRC_HI) begin
			tx_next = tx_crc[15:8];
		end
	end

	mpc_crc16 u_tx_crc (
		.clk   (clk),
		.rst   (rst),
		.ce    (ce),
		.clear (state_q == MPC_ST_EXEC),
		.en    (tx_load && state_q == MPC_ST_TX),
		.data  (tx_next),
		.crc_q (tx_crc)
	);

	// One byte stands on the output until the serial port takes it
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_q <= '0;
		end else if (ce) begin
			if (tx_load) begin
				tx_q.valid <= 1'b1;
				tx_q.data  <= tx_next;
			end else if (tx_accept) begin
				tx_q.valid <= 1'b0;
			end
		end
	end

	mpc_correct u_correct (
		.clk              (clk),
		.rst              (rst),
		.ce               (ce),
		.meas_in          (meas_in),
		.meas_in_valid    (meas_in_valid),
		.correction       (measurement_correction_q),
		.meas_out_q       (meas_out_q),
		.meas_out_valid_q (meas_out_valid_q)
	);

endmodule : mpc_config_slave

// ---- verilog/mpc_correct.sv ----
// Adds the signed correction to a measured value, clamped to the 16-bit range
`timescale 1ns/1ps
module mpc_correct
	import mpc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic [15:0] meas_in,
	input  wire logic        meas_in_valid,
	input  wire logic [15:0] correction,
	output logic      [15:0] meas_out_q,
	output logic             meas_out_valid_q
);

	logic signed [17:0] sum;

	assign sum = $signed({2'b00, meas_in}) + $signed({{2{correction[15]}}, correction});

	always_ff @(posedge clk) begin
		if (rst) begin
			meas_out_q       <= 16'h0000;
			meas_out_valid_q <= 1'b0;
		end else if (ce) begin
			meas_out_valid_q <= meas_in_valid;
			if (meas_in_valid) begin
				// Clamp rather than wrap so a small reading never turns into a huge one
				if (sum[17]) begin
					meas_out_q <= 16'h0000;
				end else if (sum[16]) begin
					meas_out_q <= 16'hFFFF;
				end else begin
					meas_out_q <= sum[15:0];
				end
			end
		end
	end

endmodule : mpc_correct

// ---- verilog/mpc_crc16.sv ----
// Byte-serial Modbus CRC-16 accumulator
`timescale 1ns/1ps
module mpc_crc16
	import mpc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        clear,
	input  wire logic        en,
	input  wire logic [7:0]  data,
	output logic      [15:0] crc_q
);

	logic [15:0] crc_d;

	always_comb begin
		crc_d = crc_q ^ {8'h00, data};
		for (int i = 0; i < 8; i++) begin
			crc_d = crc_d[0] ? ((crc_d >> 1) ^ MPC_CRC_POLY) : (crc_d >> 1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			crc_q <= MPC_CRC_INIT;
		end else if (ce) begin
			if (clear) begin
				crc_q <= MPC_CRC_INIT;
			end else if (en) begin
				crc_q <= crc_d;
			end
		end
	end

endmodule : mpc_crc16

// ---- verilog/mpc_pkg.sv ----
// Shared constants and types for the parameter-configuration command handler
package mpc_pkg;

	// Byte carried with its strobe
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} mpc_byte_t;

	// Holding register offsets
	localparam logic [15:0] MPC_REG_SLAVE_ADDRESS = 16'h0066;
	localparam logic [15:0] MPC_REG_BAUD_CODE     = 16'h0067;
	localparam logic [15:0] MPC_REG_CORRECTION    = 16'h006B;

	// Values after reset
	localparam logic [7:0]  MPC_RST_SLAVE_ADDRESS = 8'h01;
	localparam logic [2:0]  MPC_RST_BAUD_CODE     = 3'h3;
	localparam logic [15:0] MPC_RST_CORRECTION    = 16'h0000;

	// Addressing and function codes
	localparam logic [7:0]  MPC_UNIVERSAL_ADDR = 8'hFA;
	localparam logic [7:0]  MPC_FN_READ        = 8'h03;
	localparam logic [7:0]  MPC_FN_WRITE       = 8'h06;
	localparam logic [7:0]  MPC_READ_BYTES     = 8'h02;
	localparam logic [15:0] MPC_READ_QTY       = 16'h0001;

	// Accepted write ranges
	localparam logic [15:0] MPC_ADDR_MIN = 16'h0001;
	localparam logic [15:0] MPC_ADDR_MAX = 16'h00F9;
	localparam logic [15:0] MPC_BAUD_MIN = 16'h0001;
	localparam logic [15:0] MPC_BAUD_MAX = 16'h0006;
	localparam logic [15:0] MPC_CORR_POS_MAX = 16'h03E8;
	localparam logic [15:0] MPC_CORR_NEG_MIN = 16'hFC17;

	// Frame layout
	localparam logic [3:0] MPC_REQ_LEN       = 4'h8;
	localparam logic [2:0] MPC_RSP_READ_LEN  = 3'h5;
	localparam logic [2:0] MPC_RSP_WRITE_LEN = 3'h6;

	// CRC-16 seed and reflected polynomial
	localparam logic [15:0] MPC_CRC_INIT = 16'hFFFF;
	localparam logic [15:0] MPC_CRC_POLY = 16'hA001;

	// Baud rate per code
	localparam logic [16:0] MPC_BAUD_1 = 17'h00960;
	localparam logic [16:0] MPC_BAUD_2 = 17'h012C0;
	localparam logic [16:0] MPC_BAUD_3 = 17'h02580;
	localparam logic [16:0] MPC_BAUD_4 = 17'h04B00;
	localparam logic [16:0] MPC_BAUD_5 = 17'h09600;
	localparam logic [16:0] MPC_BAUD_6 = 17'h1C200;

endpackage : mpc_pkg
